// *** rtl/dtot_op_decode.sv ***
// Purpose: combinational opcode recognition and minimum clock charge
// Assumes: opcode and addressing byte already fetched
// Notes: unknown opcodes report known low, cost zero
`timescale 1ns/1ps
module dtot_op_decode (
  input dtot_pkg::dtot_req_t req,
  input wire logic narrow,
  output dtot_pkg::dtot_dec_t dec
);
  import dtot_pkg::*;

  logic reg_form;
  logic word_op;
  logic [5:0] word_add;

  assign reg_form = (req.modrm[DTOT_MOD_HI:DTOT_MOD_LO] == DTOT_MOD_REG);
  assign word_op = req.opcode[DTOT_WORD_BIT];
  // marked moves on the narrow bus pay extra per word transfer
  assign word_add = (narrow && word_op) ? DTOT_T_WORD_XFER : 6'h00;

  // charges are minimums; handshake stretch added by the core
  always_comb begin
    dec = '0;
    dec.op = DTOT_OP_NONE;
    unique case (req.opcode)
      DTOT_OPC_SEG_LOAD: begin
        dec.op = DTOT_OP_SEG_LOAD;
        dec.known = 1'b1;
        dec.mem = !reg_form;
        dec.cost = reg_form ? DTOT_T_SEG_REG : (narrow ? DTOT_T_SEGLD_MEM_N : DTOT_T_SEGLD_MEM_W);
      end
      DTOT_OPC_SEG_STORE: begin
        dec.op = DTOT_OP_SEG_STORE;
        dec.known = 1'b1;
        dec.mem = !reg_form;
        dec.cost = reg_form ? DTOT_T_SEG_REG : (narrow ? DTOT_T_SEGST_MEM_N : DTOT_T_SEGST_MEM_W);
      end
      DTOT_OPC_XLATE: begin
        dec.op = DTOT_OP_XLATE;
        dec.known = 1'b1;
        dec.mem = 1'b1;
        dec.cost = narrow ? DTOT_T_XLATE_N : DTOT_T_XLATE_W;
      end
      DTOT_OPC_EADDR: begin
        dec.op = DTOT_OP_EADDR;
        dec.known = 1'b1;
        dec.cost = DTOT_T_EADDR;
      end
      DTOT_OPC_PTR_DS, DTOT_OPC_PTR_ES: begin
        dec.op = (req.opcode == DTOT_OPC_PTR_DS) ? DTOT_OP_PTR_DS : DTOT_OP_PTR_ES;
        dec.known = 1'b1;
        dec.invalid = reg_form;
        dec.mem = !reg_form;
        dec.cost = reg_form ? 6'h00 : (narrow ? DTOT_T_PTR_N : DTOT_T_PTR_W);
      end
      DTOT_OPC_FLAGS_HI: begin
        dec.op = DTOT_OP_FLAGS_HI;
        dec.known = 1'b1;
        dec.cost = DTOT_T_FLAGS_HI;
      end
      DTOT_OPC_HI_FLAGS: begin
        dec.op = DTOT_OP_HI_FLAGS;
        dec.known = 1'b1;
        dec.cost = DTOT_T_HI_FLAGS;
      end
      default: begin
        // marked moves: byte count is the base, word adds per transfer on the narrow bus
        dec.op = DTOT_OP_MOV;
        dec.known = 1'b1;
        dec.mem = 1'b1;
        unique case (req.opcode[7:1])
          DTOT_OPC_MOV_TO_RM: begin
            dec.mem = !reg_form;
            dec.cost = reg_form ? DTOT_T_MOV_REG : 6'(DTOT_T_MOV_TO_MEM + word_add);
          end
          DTOT_OPC_MOV_FROM_RM: begin
            dec.mem = !reg_form;
            dec.cost = reg_form ? DTOT_T_MOV_REG : 6'(DTOT_T_MOV_FROM_MEM + word_add);
          end
          DTOT_OPC_MOV_MEM_ACC: begin
            dec.cost = 6'(DTOT_T_MOV_MEM_ACC + word_add);
          end
          DTOT_OPC_MOV_ACC_MEM: begin
            dec.cost = 6'(DTOT_T_MOV_ACC_MEM + word_add);
          end
          default: begin
            dec = '0;
            dec.op = DTOT_OP_NONE;
          end
        endcase
      end
    endcase
  end
endmodule

// *** rtl/dtot_pin_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for a strap pin
// Assumes: input is asynchronous to clk_sys
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module dtot_pin_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level_out
);
  import dtot_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dtot_sync_t;

  dtot_sync_t st_q;
  dtot_sync_t st_d;

  // first stage feeds only the second
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
        st_d.lvl = st_q.s3;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule

// *** rtl/dtot_pkg.sv ***
// Purpose: constants and carrier types for the data-transfer opcode timing block
// Assumes: one 200 MHz core clock, counts are execution-unit clocks
// Notes: opcode bytes and clock charges live here only
//
// Behaviour
// - segment load from reg/mem: 2 clocks reg, 9 wide or 13 narrow memory.
// - segment store to reg/mem: 2 clocks reg, 11 wide or 15 narrow memory.
// - table lookup translate of accumulator low byte: 11 wide, 15 narrow.
// - load effective address into register: 6 clocks on both variants.
// - load pointer with data segment: memory form only, 18 wide, 26 narrow.
// - load pointer with extra segment: memory form only, 18 wide, 26 narrow.
// - flags to accumulator high byte takes 2 clocks on both variants.
// - accumulator high byte to flags takes 3 clocks on both variants.
// - narrow variant marked counts are the base cost for byte operands.
// - narrow variant marked word ops add 4 clocks per memory transfer.
// - charged counts are minimums assuming prefetched, no waits, aligned.
// - memory instructions may stretch one or two clocks for unit handshake.
package dtot_pkg;

  // ----------------------------------------------------------------
  // opcode bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] DTOT_OPC_SEG_LOAD = 8'h8e;
  localparam logic [7:0] DTOT_OPC_SEG_STORE = 8'h8c;
  localparam logic [7:0] DTOT_OPC_XLATE = 8'hd7;
  localparam logic [7:0] DTOT_OPC_EADDR = 8'h8d;
  localparam logic [7:0] DTOT_OPC_PTR_DS = 8'hc5;
  localparam logic [7:0] DTOT_OPC_PTR_ES = 8'hc4;
  localparam logic [7:0] DTOT_OPC_FLAGS_HI = 8'h9f;
  localparam logic [7:0] DTOT_OPC_HI_FLAGS = 8'h9e;
  // upper seven bits of marked moves, bit 0 is the word bit
  localparam logic [6:0] DTOT_OPC_MOV_TO_RM = 7'h44;
  localparam logic [6:0] DTOT_OPC_MOV_FROM_RM = 7'h45;
  localparam logic [6:0] DTOT_OPC_MOV_MEM_ACC = 7'h50;
  localparam logic [6:0] DTOT_OPC_MOV_ACC_MEM = 7'h51;

  // ----------------------------------------------------------------
  // addressing byte fields
  // ----------------------------------------------------------------
  localparam int DTOT_MOD_HI = 7;
  localparam int DTOT_MOD_LO = 6;
  localparam logic [1:0] DTOT_MOD_REG = 2'h3;
  localparam int DTOT_WORD_BIT = 0;

  // ----------------------------------------------------------------
  // clock charges, wide / narrow bus
  // ----------------------------------------------------------------
  localparam int DTOT_CW = 6;
  localparam logic [5:0] DTOT_T_SEG_REG = 6'h02;
  localparam logic [5:0] DTOT_T_SEGLD_MEM_W = 6'h09;
  localparam logic [5:0] DTOT_T_SEGLD_MEM_N = 6'h0d;
  localparam logic [5:0] DTOT_T_SEGST_MEM_W = 6'h0b;
  localparam logic [5:0] DTOT_T_SEGST_MEM_N = 6'h0f;
  localparam logic [5:0] DTOT_T_XLATE_W = 6'h0b;
  localparam logic [5:0] DTOT_T_XLATE_N = 6'h0f;
  localparam logic [5:0] DTOT_T_EADDR = 6'h06;
  localparam logic [5:0] DTOT_T_PTR_W = 6'h12;
  localparam logic [5:0] DTOT_T_PTR_N = 6'h1a;
  localparam logic [5:0] DTOT_T_FLAGS_HI = 6'h02;
  localparam logic [5:0] DTOT_T_HI_FLAGS = 6'h03;
  localparam logic [5:0] DTOT_T_MOV_REG = 6'h02;
  localparam logic [5:0] DTOT_T_MOV_TO_MEM = 6'h0c;
  localparam logic [5:0] DTOT_T_MOV_FROM_MEM = 6'h09;
  localparam logic [5:0] DTOT_T_MOV_MEM_ACC = 6'h08;
  localparam logic [5:0] DTOT_T_MOV_ACC_MEM = 6'h09;
  localparam logic [5:0] DTOT_T_WORD_XFER = 6'h04;
  localparam logic [1:0] DTOT_HANDSHAKE_MAX = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DTOT_OP_NONE = 4'h0,
    DTOT_OP_SEG_LOAD = 4'h1,
    DTOT_OP_SEG_STORE = 4'h2,
    DTOT_OP_XLATE = 4'h3,
    DTOT_OP_EADDR = 4'h4,
    DTOT_OP_PTR_DS = 4'h5,
    DTOT_OP_PTR_ES = 4'h6,
    DTOT_OP_FLAGS_HI = 4'h7,
    DTOT_OP_HI_FLAGS = 4'h8,
    DTOT_OP_MOV = 4'h9
  } dtot_op_t;

  typedef enum logic [1:0] {
    DTOT_ST_IDLE = 2'h0,
    DTOT_ST_RUN = 2'h1,
    DTOT_ST_HAND = 2'h3
  } dtot_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } dtot_req_t;

  typedef struct packed {
    dtot_op_t op;
    logic known;
    logic invalid;
    logic mem;
    logic [5:0] cost;
  } dtot_dec_t;

  typedef struct packed {
    logic done;
    logic invalid;
    dtot_op_t op;
    logic [5:0] cycles;
  } dtot_rsp_t;

  typedef struct packed {
    dtot_state_t st;
    logic ready;
    logic busy;
    logic mem_wait;
    dtot_rsp_t rsp;
    logic mem;
    logic [5:0] cost;
    logic [5:0] cnt;
    logic [1:0] extra;
  } dtot_core_t;

endpackage

// *** rtl/dtot_timing_core.sv ***
// Purpose: accept data-transfer opcodes, decode them and time their execution
// Assumes: requests come from logic on clk_sys; bus width strap is a pin
// Notes: response pulses once per accepted opcode, busy covers the charge
`timescale 1ns/1ps
module dtot_timing_core (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic narrow_bus_pin,
  input wire logic req_valid,
  input dtot_pkg::dtot_req_t req,
  input wire logic biu_ack,
  output logic req_ready,
  output logic busy,
  output logic mem_wait,
  output logic narrow_bus,
  output dtot_pkg::dtot_rsp_t rsp
);
  import dtot_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // async assert, two-flop release so all state leaves reset together
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // bus width strap
  // ----------------------------------------------------------------
  logic narrow_lvl;

  // strap may be tied off-chip, so filter it like any pin
  dtot_pin_sync u_width_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .clk_en(clk_en),
    .pin_in(narrow_bus_pin),
    .level_out(narrow_lvl)
  );

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  dtot_dec_t dec;

  dtot_op_decode u_decode (
    .req(req),
    .narrow(narrow_lvl),
    .dec(dec)
  );

  // ----------------------------------------------------------------
  // execution timer
  // ----------------------------------------------------------------
  dtot_core_t st_q;
  dtot_core_t st_d;
  logic take;
  logic last_min;
  logic [1:0] extra_inc;
  logic hand_end;

  // request taken only while idle and ready
  assign take = req_valid && st_q.ready && (st_q.st == DTOT_ST_IDLE);
  // final cycle of the minimum charge
  assign last_min = (st_q.st == DTOT_ST_RUN) && (st_q.cnt == 6'h01);
  assign extra_inc = 2'(st_q.extra + 2'h1);
  // handshake stretch is bounded so a stuck ack cannot hang the core
  assign hand_end = biu_ack || (extra_inc == DTOT_HANDSHAKE_MAX);

  // next-state of the whole core
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      // done is a pulse of one enabled cycle
      st_d.rsp.done = 1'b0;
      unique case (st_q.st)
        DTOT_ST_IDLE: begin
          if (take) begin
            st_d.rsp.op = dec.op;
            st_d.rsp.invalid = !dec.known || dec.invalid;
            if (!dec.known || dec.invalid) begin
              // refused opcodes finish at once with no charge
              st_d.rsp.done = 1'b1;
              st_d.rsp.cycles = 6'h00;
            end else begin
              st_d.st = DTOT_ST_RUN;
              st_d.ready = 1'b0;
              st_d.busy = 1'b1;
              st_d.mem = dec.mem;
              st_d.cost = dec.cost;
              st_d.cnt = dec.cost;
              st_d.extra = 2'h0;
            end
          end
        end
        DTOT_ST_RUN: begin
          st_d.cnt = 6'(st_q.cnt - 6'h01);
          if (last_min) begin
            if (st_q.mem && !biu_ack) begin
              // memory op whose transfer is not yet confirmed
              st_d.st = DTOT_ST_HAND;
              st_d.mem_wait = 1'b1;
            end else begin
              st_d.st = DTOT_ST_IDLE;
              st_d.ready = 1'b1;
              st_d.busy = 1'b0;
              st_d.rsp.done = 1'b1;
              st_d.rsp.cycles = st_q.cost;
            end
          end
        end
        DTOT_ST_HAND: begin
          st_d.extra = extra_inc;
          if (hand_end) begin
            st_d.st = DTOT_ST_IDLE;
            st_d.ready = 1'b1;
            st_d.busy = 1'b0;
            st_d.mem_wait = 1'b0;
            st_d.rsp.done = 1'b1;
            st_d.rsp.cycles = 6'(st_q.cost + {4'h0, extra_inc});
          end
        end
        default: begin
          // illegal code: drop back to a clean idle
          st_d = '0;
          st_d.st = DTOT_ST_IDLE;
          st_d.ready = 1'b1;
        end
      endcase
    end
  end

  // state register; reset loads ready high, so ready is already up during reset
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= '{st: DTOT_ST_IDLE, ready: 1'b1, rsp: '{op: DTOT_OP_NONE, default: '0}, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign req_ready = st_q.ready;
  assign busy = st_q.busy;
  assign mem_wait = st_q.mem_wait;
  assign rsp = st_q.rsp;

  // strap level as the core sees it, for the bus unit's own use
  assign narrow_bus = narrow_lvl;
endmodule

// *** sim/data_transfer_opcode_timing_tb.sv ***
// Purpose: self-checking bench for the data-transfer opcode timing core
// Assumes: clk_en high except in the freeze case, strap settles within ten cycles
// Notes: table rows first, then stretch and reset cases
`timescale 1ns/1ps
module data_transfer_opcode_timing_tb;
  import dtot_pkg::*;
  typedef struct packed {logic nb; logic [7:0] opc; logic [7:0] modrm; dtot_op_t op; logic inv; logic [5:0] cyc;} dtot_row_t;
  logic clk_sys, rstn, clk_en, narrow_bus_pin, req_valid, biu_ack, req_ready, busy, mem_wait, narrow_bus;
  dtot_req_t req;
  dtot_rsp_t rsp;
  int miscompares, check_count, lat;
  dtot_row_t rows [27];
  dtot_timing_core dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .narrow_bus_pin(narrow_bus_pin),
    .req_valid(req_valid), .req(req), .biu_ack(biu_ack), .req_ready(req_ready), .busy(busy),
    .mem_wait(mem_wait), .narrow_bus(narrow_bus), .rsp(rsp));
  // 200 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // mode 0 ack held high, 1 ack never, 2 ack once the stretch shows
  task automatic issue(logic [7:0] opc, logic [7:0] modrm, int mode);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{opcode: opc, modrm: modrm};
    biu_ack <= (mode == 0);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    lat = 0;
    #1;
    while (rsp.done !== 1'b1 && lat < 40) begin
      @(posedge clk_sys);
      lat++;
      #1;
      if (mode == 2 && mem_wait === 1'b1) biu_ack <= 1'b1;
    end
    check("done_seen", rsp.done, 16'h1);
    biu_ack <= 1'b0;
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rstn = 1'b0; clk_en = 1'b1; narrow_bus_pin = 1'b0; req_valid = 1'b0; biu_ack = 1'b0; req = '0;
    miscompares = 0; check_count = 0;
    rows = '{
      '{1'h0, 8'h8e, 8'hc0, DTOT_OP_SEG_LOAD, 1'h0, 6'h02}, '{1'h0, 8'h8e, 8'h00, DTOT_OP_SEG_LOAD, 1'h0, 6'h09},
      '{1'h0, 8'h8c, 8'hc0, DTOT_OP_SEG_STORE, 1'h0, 6'h02}, '{1'h0, 8'h8c, 8'h00, DTOT_OP_SEG_STORE, 1'h0, 6'h0b},
      '{1'h0, 8'hd7, 8'h00, DTOT_OP_XLATE, 1'h0, 6'h0b}, '{1'h0, 8'h8d, 8'h00, DTOT_OP_EADDR, 1'h0, 6'h06},
      '{1'h0, 8'hc5, 8'h00, DTOT_OP_PTR_DS, 1'h0, 6'h12}, '{1'h0, 8'hc4, 8'h00, DTOT_OP_PTR_ES, 1'h0, 6'h12},
      '{1'h0, 8'hc5, 8'hc0, DTOT_OP_NONE, 1'h1, 6'h00}, '{1'h0, 8'h9f, 8'h00, DTOT_OP_FLAGS_HI, 1'h0, 6'h02},
      '{1'h0, 8'h9e, 8'h00, DTOT_OP_HI_FLAGS, 1'h0, 6'h03}, '{1'h0, 8'h89, 8'h00, DTOT_OP_MOV, 1'h0, 6'h0c},
      '{1'h0, 8'h00, 8'h00, DTOT_OP_NONE, 1'h1, 6'h00}, '{1'h1, 8'h8e, 8'h00, DTOT_OP_SEG_LOAD, 1'h0, 6'h0d},
      '{1'h1, 8'h8c, 8'h00, DTOT_OP_SEG_STORE, 1'h0, 6'h0f}, '{1'h1, 8'hd7, 8'h00, DTOT_OP_XLATE, 1'h0, 6'h0f},
      '{1'h1, 8'h8d, 8'h00, DTOT_OP_EADDR, 1'h0, 6'h06}, '{1'h1, 8'hc5, 8'h00, DTOT_OP_PTR_DS, 1'h0, 6'h1a},
      '{1'h1, 8'hc4, 8'hc0, DTOT_OP_NONE, 1'h1, 6'h00}, '{1'h1, 8'hc4, 8'h00, DTOT_OP_PTR_ES, 1'h0, 6'h1a},
      '{1'h1, 8'h9f, 8'h00, DTOT_OP_FLAGS_HI, 1'h0, 6'h02}, '{1'h1, 8'h9e, 8'h00, DTOT_OP_HI_FLAGS, 1'h0, 6'h03},
      '{1'h1, 8'h8a, 8'h00, DTOT_OP_MOV, 1'h0, 6'h09}, '{1'h1, 8'h8b, 8'h00, DTOT_OP_MOV, 1'h0, 6'h0d},
      '{1'h1, 8'ha1, 8'h00, DTOT_OP_MOV, 1'h0, 6'h0c}, '{1'h1, 8'h89, 8'hc0, DTOT_OP_MOV, 1'h0, 6'h02},
      '{1'h1, 8'ha2, 8'h00, DTOT_OP_MOV, 1'h0, 6'h09}};
    repeat (8) @(posedge clk_sys);
    check("ready_in_reset", req_ready, 16'h1);
    check("rsp_in_reset", rsp, 16'h0);
    rstn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    // table walk, strap moved only between rows
    foreach (rows[i]) begin
      if (narrow_bus_pin !== rows[i].nb) begin
        narrow_bus_pin <= rows[i].nb;
        repeat (10) @(posedge clk_sys);
        check("narrow_bus", narrow_bus, rows[i].nb);
      end
      issue(rows[i].opc, rows[i].modrm, 0);
      check("latency", lat, rows[i].inv ? 0 : rows[i].cyc);
      check("cycles", rsp.cycles, rows[i].cyc);
      check("invalid", rsp.invalid, rows[i].inv);
      if (!rows[i].inv) check("op", rsp.op, rows[i].op);
    end
    // handshake stretch, capped at two extra clocks
    issue(8'hd7, 8'h00, 1);
    check("stretch_two", rsp.cycles, 16'h11);
    issue(8'hd7, 8'h00, 2);
    check("stretch_one", rsp.cycles, 16'h10);
    // reset in mid-charge must abandon the opcode
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{opcode: 8'hd7, modrm: 8'h00};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b0;
    #1;
    check("busy_reset", busy, 16'h0);
    check("ready_reset", req_ready, 16'h1);
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    issue(8'h9e, 8'h00, 0);
    check("after_reset", lat, 16'h3);
    // four frozen edges stretch wall time but never the charge itself
    fork
      begin
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        clk_en <= 1'b1;
      end
      issue(8'h8c, 8'h00, 0);
    join
    check("frozen_lat", lat, 16'h13);
    check("frozen_cycles", rsp.cycles, 16'h0f);
    end_sim();
  end
  // hang guard, the whole run needs well under ten thousand cycles
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
endmodule

// *** sim/dtot_timing_assertions.sv ***
// Purpose: timing checks on the data-transfer opcode timing core ports
// Assumes: clk_en held high while an opcode is being charged
// Notes: bound to every instance of the core
`timescale 1ns/1ps
module dtot_timing_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic narrow_bus_pin,
  input wire logic req_valid,
  input dtot_pkg::dtot_req_t req,
  input wire logic biu_ack,
  input wire logic req_ready,
  input wire logic busy,
  input wire logic mem_wait,
  input wire logic narrow_bus,
  input dtot_pkg::dtot_rsp_t rsp
);
  import dtot_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------
  // request decode helpers
  // ------------------------------------------------
  wire take = clk_en && req_valid && req_ready;
  wire mem_form = req.modrm[7:6] != DTOT_MOD_REG;
  wire ptr_op = req.opcode == DTOT_OPC_PTR_DS || req.opcode == DTOT_OPC_PTR_ES;
  // ------------------------------------------------
  // charge per opcode
  // ------------------------------------------------
  a_seg_reg_two: assert property (
    take && !mem_form && (req.opcode == DTOT_OPC_SEG_LOAD || req.opcode == DTOT_OPC_SEG_STORE)
    |-> ##3 (rsp.done && rsp.cycles == DTOT_T_SEG_REG)) else $error("segment register form timing wrong");
  a_xlate_wide: assert property (
    take && req.opcode == DTOT_OPC_XLATE && !narrow_bus
    |-> ##[12:14] (rsp.done && rsp.cycles >= 6'h0b && rsp.cycles <= 6'h0d)) else $error("wide translate charge wrong");
  a_xlate_narrow: assert property (
    take && req.opcode == DTOT_OPC_XLATE && narrow_bus
    |-> ##[16:18] (rsp.done && rsp.cycles >= 6'h0f && rsp.cycles <= 6'h11)) else $error("narrow translate charge wrong");
  a_eaddr_six: assert property (
    take && req.opcode == DTOT_OPC_EADDR
    |=> (!rsp.done)[*6] ##1 (rsp.done && rsp.cycles == DTOT_T_EADDR)) else $error("address load charge wrong");
  a_ptr_mem_narrow: assert property (
    take && ptr_op && mem_form && narrow_bus
    |-> ##[27:29] (rsp.done && rsp.cycles >= DTOT_T_PTR_N && rsp.cycles <= 6'h1c)) else $error("narrow pointer load charge wrong");
  a_ptr_reg_inv: assert property (
    take && ptr_op && !mem_form
    |=> rsp.done && rsp.invalid && rsp.cycles == 6'h00) else $error("register form pointer load not refused");
  a_flags_hi: assert property (
    take && req.opcode == DTOT_OPC_FLAGS_HI
    |-> ##3 (rsp.done && rsp.op == DTOT_OP_FLAGS_HI && rsp.cycles == DTOT_T_FLAGS_HI)) else $error("flags copy wrong");
  a_busy_span: assert property (
    take && req.opcode == DTOT_OPC_HI_FLAGS
    |=> busy[*3] ##1 (!busy && rsp.done && rsp.cycles == DTOT_T_HI_FLAGS)) else $error("flags write span wrong");
  a_word_narrow: assert property (
    take && req.opcode == {DTOT_OPC_MOV_FROM_RM, 1'b1} && mem_form && narrow_bus
    |-> ##[14:16] (rsp.done && rsp.cycles >= 6'h0d && rsp.cycles <= 6'h0f)) else $error("narrow word add missing");
  a_stretch_cap: assert property (
    $rose(mem_wait) |-> ##[1:2] rsp.done) else $error("handshake stretch too long");
  // main scenarios reached
  c_ptr_refused: cover property (take && ptr_op && !mem_form);
  c_stretch: cover property ($rose(mem_wait));
  c_ptr_narrow: cover property (rsp.done && rsp.cycles == DTOT_T_PTR_N);
endmodule

bind dtot_timing_core dtot_timing_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
  .narrow_bus_pin(narrow_bus_pin), .req_valid(req_valid), .req(req), .biu_ack(biu_ack), .req_ready(req_ready),
  .busy(busy), .mem_wait(mem_wait), .narrow_bus(narrow_bus), .rsp(rsp));
